// ==== hw/gfc_pkg.sv ====
// constants and types of the gated frequency counter
// Function
// [R1] software selects external count clock first
// [R2] count input edges only while gate high
// [R3] gate select 00 takes external gate pin
// [R4] interrupt on gate fall or both edges
// [R5] handler reads result, then clears counter
// [R6] uncleared counter resumes from held value
// [R7] status bit shows current gate level
// [R8] wrap from all ones sets overflow
// [R9] overflow holds until counter clear
// [R10] routing bit zero drives companion to pin
// [R11] routing bit touches only pin path
// [R12] fast tap: (16-set) times 2^12..14 cycles
// [R13] slow tap: (16-set) times 2^4..6 ticks
// [R14] gate alternates high and low periods
// [R15] first period may start one tick late
// [R16] change periods only stopped or low
// [R17] new low setting applies next low
// [R18] edge select one: gate fall adds one
// [R19] edge select zero: count falls of AND
// [R20] counter and result are 18 bits
package gfc_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL1_OFS  = 8'h00;
   localparam logic [7:0] CTRL2_OFS  = 8'h04;
   localparam logic [7:0] RESULT_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   localparam logic [7:0] PERIOD_OFS = 8'h10;
   // control one fields
   localparam int CTRL1_RUN_BIT   = 0;
   localparam int CTRL1_CLEAR_BIT = 1;
   localparam int CTRL1_SRC_LSB   = 2;
   // control two fields
   localparam int CTRL2_GSEL_LSB  = 0;
   localparam int CTRL2_EDGE_BIT  = 2;
   localparam int CTRL2_SEG_BIT   = 3;
   localparam int CTRL2_ROUTE_BIT = 4;
   localparam int CTRL2_PS_LSB    = 5;
   localparam int CTRL2_TAP_BIT   = 7;
   // status and period fields
   localparam int STATUS_GATE_BIT = 0;
   localparam int STATUS_OVF_BIT  = 1;
   localparam int PERIOD_HI_LSB   = 0;
   localparam int PERIOD_LO_LSB   = 4;
   // reset values
   localparam logic [7:0] CTRL1_RST  = 8'h00;
   localparam logic [7:0] CTRL2_RST  = 8'h00;
   localparam logic [7:0] PERIOD_RST = 8'h00;
   // encodings
   localparam logic [1:0] SRC_EXTERNAL   = 2'h3;
   localparam logic [1:0] GSEL_PIN       = 2'h0;
   localparam logic [1:0] GSEL_COMPANION = 2'h1;
   localparam logic [1:0] GSEL_INTERNAL  = 2'h2;
   // gate timing counts
   localparam logic [4:0] GATE_SPAN   = 5'h10;
   localparam int         FAST_EXP    = 12;
   localparam int         SLOW_EXP    = 4;
   localparam int         FAST_DIV_W  = 14;
   localparam int         SLOW_DIV_W  = 6;
   localparam int         SYNC_STAGES = 3;

   typedef enum logic [1:0] {
      GFC_IDLE = 2'b00,
      GFC_HIGH = 2'b01,
      GFC_LOW  = 2'b10
   } gfc_gate_state_t;
endpackage : gfc_pkg

// ==== hw/gfc_gate_if.sv ====
// link between the counter core and the internal gate generator
interface gfc_gate_if;
   logic       run;
   logic       useLow;
   logic       fsTick;
   logic [1:0] prescale;
   logic [3:0] highSet;
   logic [3:0] lowSet;
   logic       gate;
   modport gen (input run, input useLow, input fsTick, input prescale,
                input highSet, input lowSet, output gate);
   modport core (output run, output useLow, output fsTick, output prescale,
                 output highSet, output lowSet, input gate);
endinterface : gfc_gate_if

// ==== hw/gfc_gate_gen.sv ====
// internal window gate generator locked to the prescaler
module gfc_gate_gen
   import gfc_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic reset_n,
   gfc_gate_if.gen   gi
);
   logic [FAST_DIV_W-1:0] divFc_r;
   logic [SLOW_DIV_W-1:0] divFs_r;
   logic [FAST_DIV_W-1:0] maskFc;
   logic [SLOW_DIV_W-1:0] maskFs;
   logic                  tick;
   logic [4:0]            rem_r;
   gfc_gate_state_t       state_r;
   logic [1:0]            psEff;

   // prescale code 11 behaves as 10
   assign psEff  = (gi.prescale == 2'h3) ? 2'h2 : gi.prescale;
   assign maskFc = FAST_DIV_W'((32'h1 << (FAST_EXP + int'(psEff))) - 1);
   assign maskFs = SLOW_DIV_W'((32'h1 << (SLOW_EXP + int'(psEff))) - 1);

   // free-running fast divider
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         divFc_r <= '0;
      else
         divFc_r <= divFc_r + 1'b1;
   end

   // slow divider advances on low-frequency clock ticks
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         divFs_r <= '0;
      else if (gi.fsTick)
         divFs_r <= divFs_r + 1'b1;
   end

   // [R12] [R13] prescaler tick selection
   assign tick = gi.useLow ? (gi.fsTick && ((divFs_r & maskFs) == '0))
                           : ((divFc_r & maskFc) == '0);

   // period sequencer
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state_r <= GFC_IDLE;
         rem_r   <= '0;
      end
      else if (!gi.run)
         state_r <= GFC_IDLE;
      else if (tick)
      begin
         unique case (state_r)
            // [R15] start waits for divider tick
            GFC_IDLE:
            begin
               state_r <= GFC_HIGH;
               rem_r   <= GATE_SPAN - {1'b0, gi.highSet};
            end
            // [R14] high then low period
            GFC_HIGH:
            begin
               if (rem_r == 5'h01)
               begin
                  state_r <= GFC_LOW;
                  // [R17] low setting sampled on entry
                  rem_r   <= GATE_SPAN - {1'b0, gi.lowSet};
               end
               else
                  rem_r <= rem_r - 1'b1;
            end
            GFC_LOW:
            begin
               if (rem_r == 5'h01)
               begin
                  state_r <= GFC_HIGH;
                  rem_r   <= GATE_SPAN - {1'b0, gi.highSet};
               end
               else
                  rem_r <= rem_r - 1'b1;
            end
            default:
               state_r <= GFC_IDLE;
         endcase
      end
   end

   assign gi.gate = (state_r == GFC_HIGH);
endmodule : gfc_gate_gen

// ==== hw/gfc_counter.sv ====
// gated frequency counter with apb register access
//
// Register access over APB and the placing of the registers were chosen for this implementation.
module gfc_counter
   import gfc_pkg::*;
#(
   parameter int CNT_W = 18
)
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        countInputPin,
   input  wire logic        externalGatePin,
   input  wire logic        lowClkPin,
   input  wire logic        slowMode,
   input  wire logic        companionPwmOutput,
   output logic             sharedPortPinOut,
   output logic             sharedPortPinOe,
   output logic             timer1Interrupt
);
   gfc_gate_if gi ();

   logic [7:0]       ctrl1_r;
   logic [7:0]       ctrl2_r;
   logic [7:0]       period_r;
   logic [CNT_W-1:0] counter_r;
   logic             overflow_r;
   logic [31:0]      prdata_r;
   logic             pready_r;
   logic             pslverr_r;
   logic [2:0]       pinIn;
   logic [2:0]       stg1_r;
   logic [2:0]       stg2_r;
   logic [2:0]       stg3_r;
   logic [2:0]       filt_r;
   logic             lowPrev_r;
   logic             fsTick_r;
   logic             gateSel_r;
   logic             gatePrev_r;
   logic             cntPrev_r;
   logic             irq_r;
   logic             pinOut_r;
   logic             pinOe_r;
   logic             wrEn;
   logic             clearReq;
   logic             counting;
   logic             inc;
   logic             gateNow;
   logic             cntNow;
   logic             addrOk;
   logic [31:0]      rdVal;

   assign pinIn = {lowClkPin, externalGatePin, countInputPin};

   // three-stage synchroniser per pin, level accepted when the last two stages agree
   generate
      for (genvar i = 0; i < SYNC_STAGES; i++)
      begin : g_sync
         always_ff @(posedge ref_clk)
         begin
            if (!reset_n)
            begin
               stg1_r[i] <= 1'b0;
               stg2_r[i] <= 1'b0;
               stg3_r[i] <= 1'b0;
               filt_r[i] <= 1'b0;
            end
            else
            begin
               stg1_r[i] <= pinIn[i];
               stg2_r[i] <= stg1_r[i];
               stg3_r[i] <= stg2_r[i];
               if (stg2_r[i] == stg3_r[i])
                  filt_r[i] <= stg3_r[i];
            end
         end
      end
   endgenerate

   assign cntNow = filt_r[0];

   // low-frequency clock rising edge becomes a tick
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         lowPrev_r <= 1'b0;
         fsTick_r  <= 1'b0;
      end
      else
      begin
         lowPrev_r <= filt_r[2];
         fsTick_r  <= filt_r[2] & ~lowPrev_r;
      end
   end

   // drive the generator link
   assign gi.run      = ctrl1_r[CTRL1_RUN_BIT];
   assign gi.useLow   = slowMode | ctrl2_r[CTRL2_TAP_BIT];
   assign gi.fsTick   = fsTick_r;
   assign gi.prescale = ctrl2_r[CTRL2_PS_LSB +: 2];
   assign gi.highSet  = period_r[PERIOD_HI_LSB +: 4];
   assign gi.lowSet   = period_r[PERIOD_LO_LSB +: 4];

   gfc_gate_gen u_gate (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .gi      (gi)
   );

   // gate source multiplexer
   always_comb
   begin
      unique case (ctrl2_r[CTRL2_GSEL_LSB +: 2])
         // [R3] select 00 takes gate pin
         GSEL_PIN:       gateNow = filt_r[1];
         GSEL_COMPANION: gateNow = companionPwmOutput;
         GSEL_INTERNAL:  gateNow = gi.gate;
         default:        gateNow = 1'b0;
      endcase
   end

   // registered gate and count history
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         gateSel_r  <= 1'b0;
         gatePrev_r <= 1'b0;
         cntPrev_r  <= 1'b0;
      end
      else
      begin
         gateSel_r  <= gateNow;
         gatePrev_r <= gateSel_r;
         cntPrev_r  <= cntNow;
      end
   end

   // apb handshake decode
   assign wrEn     = psel & penable & pready_r & pwrite & addrOk;
   assign clearReq = wrEn && (paddr == CTRL1_OFS) && pwdata[CTRL1_CLEAR_BIT];
   assign addrOk   = (paddr == CTRL1_OFS) || (paddr == CTRL2_OFS)
                     || (paddr == RESULT_OFS) || (paddr == STATUS_OFS)
                     || (paddr == PERIOD_OFS);

   // software-written registers, clear bit is a strobe
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         ctrl1_r  <= CTRL1_RST;
         ctrl2_r  <= CTRL2_RST;
         period_r <= PERIOD_RST;
      end
      else if (wrEn)
      begin
         if (paddr == CTRL1_OFS)
            ctrl1_r <= pwdata[7:0] & ~(8'h01 << CTRL1_CLEAR_BIT);
         if (paddr == CTRL2_OFS)
            ctrl2_r <= pwdata[7:0];
         if (paddr == PERIOD_OFS)
            period_r <= pwdata[7:0];
      end
   end

   // [R1] counting needs run and external source
   assign counting = ctrl1_r[CTRL1_RUN_BIT]
                     && (ctrl1_r[CTRL1_SRC_LSB +: 2] == SRC_EXTERNAL);

   // increment decision per edge mode
   always_comb
   begin
      if (ctrl2_r[CTRL2_SEG_BIT])
         // [R18] both input edges, gate fall adds one
         inc = counting && gatePrev_r
               && ((gateSel_r && (cntNow != cntPrev_r)) || !gateSel_r);
      else
         // [R19] [R2] falls of input and gate
         inc = counting && cntPrev_r && gatePrev_r && !(cntNow && gateSel_r);
   end

   // [R20] [R6] up-counter holds between windows
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         counter_r <= '0;
      else if (clearReq)
         counter_r <= '0;
      else if (inc)
         counter_r <= counter_r + 1'b1;
   end

   // [R8] [R9] sticky overflow, wrap beats clear
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         overflow_r <= 1'b0;
      else if (inc && (counter_r == '1))
         overflow_r <= 1'b1;
      else if (clearReq)
         overflow_r <= 1'b0;
   end

   // [R4] interrupt pulse on selected gate edges
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         irq_r <= 1'b0;
      else
         irq_r <= ctrl1_r[CTRL1_RUN_BIT]
                  && ((gatePrev_r && !gateSel_r)
                      || (ctrl2_r[CTRL2_EDGE_BIT] && !gatePrev_r && gateSel_r));
   end

   // [R10] [R11] companion output routed to shared pin
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         pinOut_r <= 1'b0;
         pinOe_r  <= 1'b0;
      end
      else
      begin
         pinOut_r <= companionPwmOutput & ~ctrl2_r[CTRL2_ROUTE_BIT];
         pinOe_r  <= ~ctrl2_r[CTRL2_ROUTE_BIT];
      end
   end

   // read mux
   always_comb
   begin
      rdVal = 32'h0000_0000;
      unique case (paddr)
         CTRL1_OFS:  rdVal[7:0] = ctrl1_r;
         CTRL2_OFS:  rdVal[7:0] = ctrl2_r;
         // [R5] result readable after window
         RESULT_OFS: rdVal[CNT_W-1:0] = counter_r;
         STATUS_OFS:
         begin
            // [R7] gate level monitor
            rdVal[STATUS_GATE_BIT] = gateSel_r;
            rdVal[STATUS_OVF_BIT]  = overflow_r;
         end
         PERIOD_OFS: rdVal[7:0] = period_r;
         default:    rdVal = 32'h0000_0000;
      endcase
   end

   // zero-wait answer: ready raised in first access cycle
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else if (psel && !penable)
      begin
         pready_r  <= 1'b1;
         pslverr_r <= ~addrOk;
         prdata_r  <= pwrite ? 32'h0000_0000 : rdVal;
      end
      else
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   assign prdata           = prdata_r;
   assign pready           = pready_r;
   assign pslverr          = pslverr_r;
   assign sharedPortPinOut = pinOut_r;
   assign sharedPortPinOe  = pinOe_r;
   assign timer1Interrupt  = irq_r;
endmodule : gfc_counter

// ==== dv/gfc_pulse_src.sv ====
// pulse source, gate pin and low clock model facing the counter
module gfc_pulse_src
(
   input  wire logic ref_clk,
   output logic      countInputPin,
   output logic      externalGatePin,
   output logic      lowClkPin
);
   timeunit 1ns;
   timeprecision 1ns;
   int lowCnt = 0;
   initial
   begin
      countInputPin = 1'b0;
      externalGatePin = 1'b0;
      lowClkPin = 1'b0;
   end
   // free running low clock, ten ref cycles a period
   always @(posedge ref_clk)
   begin
      lowCnt <= (lowCnt == 4) ? 0 : lowCnt + 1;
      if (lowCnt == 4)
         lowClkPin <= ~lowClkPin;
   end
   // set gate and count input levels
   task automatic drive(input logic g, input logic c);
      externalGatePin <= g;
      countInputPin <= c;
   endtask : drive
   // burst of pulses, each level held for half cycles
   task automatic pulses(input int n, input int half);
      repeat (n)
      begin
         countInputPin <= 1'b1;
         repeat (half) @(posedge ref_clk);
         countInputPin <= 1'b0;
         repeat (half) @(posedge ref_clk);
      end
   endtask : pulses
endmodule : gfc_pulse_src

// ==== dv/gfc_counter_sva.sv ====
// port checker of the gated frequency counter
module gfc_counter_sva
   import gfc_pkg::*;
#(
   parameter int CNT_W = 18
)
(
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        companionPwmOutput,
   input wire logic        sharedPortPinOut,
   input wire logic        sharedPortPinOe,
   input wire logic        timer1Interrupt
);
   logic apbWr;
   logic run_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // completed apb write
   assign apbWr = psel && penable && pready && pwrite;
   // shadow of the run bit
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         run_r <= 1'b0;
      else if (apbWr && paddr == CTRL1_OFS)
         run_r <= pwdata[CTRL1_RUN_BIT];
   end
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_refuse_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access not clean");
   a_irq_single: assert property ($rose(timer1Interrupt) |=> !timer1Interrupt)
      else $error("interrupt pulse too long");
   a_irq_needs_run: assert property (!run_r && !$past(run_r) |-> !timer1Interrupt)
      else $error("interrupt while stopped");
   a_route_enable: assert property (apbWr && paddr == CTRL2_OFS |->
      ##2 sharedPortPinOe == !$past(pwdata[CTRL2_ROUTE_BIT], 2))
      else $error("pin enable not following routing bit");
   a_pin_withheld: assert property (!sharedPortPinOe |-> !sharedPortPinOut)
      else $error("withheld pin not low");
   a_pin_follows: assert property (sharedPortPinOe && $past(sharedPortPinOe) |->
      sharedPortPinOut == $past(companionPwmOutput))
      else $error("pin not following companion");
   cover property (pslverr);
   cover property (timer1Interrupt);
   cover property ($fell(sharedPortPinOe));
endmodule : gfc_counter_sva

bind gfc_counter gfc_counter_sva #(.CNT_W(CNT_W)) u_sva (.ref_clk, .reset_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .companionPwmOutput,
   .sharedPortPinOut, .sharedPortPinOe, .timer1Interrupt);

// ==== dv/gated_frequency_counter_test.sv ====
// self-checking bench of the gated frequency counter
module gated_frequency_counter_test import gfc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        slowMode = 1'b0;
   logic        companionPwmOutput = 1'b0;
   logic [15:0] seed = 16'h5DD4;
   logic [2:0]  compHist = 3'h0;
   logic [31:0] prdata, rdData;
   logic        pready, pslverr, rdErr, seg, both, hold;
   logic        countInputPin, externalGatePin, lowClkPin;
   logic        sharedPortPinOut, sharedPortPinOe, timer1Interrupt;
   int          error_cnt = 0, n_checks = 0, cyc = 0, irqs = 0, lastIrq = 0;
   int          acc, n, k, ps, ta, tb, t0, t1, t2;

   gfc_counter u_dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .countInputPin, .externalGatePin, .lowClkPin,
      .slowMode, .companionPwmOutput, .sharedPortPinOut, .sharedPortPinOe,
      .timer1Interrupt);
   gfc_pulse_src u_src (.ref_clk, .countInputPin, .externalGatePin, .lowClkPin);

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic int expCount(input int n, input logic seg, input logic hold);
      return seg ? 2 * n + 1 : n + hold;
   endfunction : expCount
   function automatic int expPer(input int set, input int ps, input logic fast);
      return (16 - set) * (fast ? (1 << (12 + ps)) : (10 << (4 + ps)));
   endfunction : expPer
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // request stands until ready is seen high at a rising edge
      while (pready !== 1'b1)
         @(posedge ref_clk);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge keeps the next setup apart from this release
      @(posedge ref_clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      check(what, rdData, exp);
   endtask : rd
   task automatic waitIrq(output int t);
      int c;
      c = irqs;
      while (irqs == c)
         @(posedge ref_clk);
      t = lastIrq;
   endtask : waitIrq
   task automatic give_verdict();
      if (error_cnt == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict

   // clock
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // random source, companion waveform, cycle and interrupt counts
   always @(posedge ref_clk)
   begin
      seed <= lfsr(seed);
      companionPwmOutput <= seed[3];
      compHist <= {compHist[1:0], companionPwmOutput};
      cyc <= cyc + 1;
      if (timer1Interrupt === 1'b1)
      begin
         irqs <= irqs + 1;
         lastIrq <= cyc;
      end
   end
   // watchdog
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      error_cnt++;
      give_verdict();
   end
   // main sequence
   initial
   begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(CTRL1_OFS, {24'h0, CTRL1_RST}, "ctrl1 reset");
      rd(CTRL2_OFS, {24'h0, CTRL2_RST}, "ctrl2 reset");
      rd(PERIOD_OFS, {24'h0, PERIOD_RST}, "period reset");
      rd(8'h14, 32'h0, "unmapped read");
      check("unmapped error", {31'h0, rdErr}, 32'h1);
      apb(1'b1, CTRL1_OFS, 32'h0000000D);
      acc = 0;
      for (int i = 0; i < 5; i++)
      begin
         seg = (i >= 3);
         both = (i == 2);
         hold = (i == 1);
         n = (i == 4) ? 0 : 1 + int'(seed[2:0]);
         if (i == 3)
         begin
            apb(1'b1, CTRL1_OFS, 32'h0000000F);
            acc = 0;
            rd(RESULT_OFS, 32'h0, "cleared result");
         end
         apb(1'b1, CTRL2_OFS, {28'h0, seg, both, 2'b00});
         k = irqs;
         u_src.drive(1'b1, 1'b0);
         repeat (12) @(posedge ref_clk);
         rd(STATUS_OFS, 32'h1, "gate high status");
         u_src.pulses(n, 4 + int'(seed[1:0]));
         u_src.drive(1'b1, hold);
         repeat (12) @(posedge ref_clk);
         u_src.drive(1'b0, hold);
         repeat (12) @(posedge ref_clk);
         u_src.drive(1'b0, 1'b0);
         repeat (12) @(posedge ref_clk);
         acc += expCount(n, seg, hold);
         rd(RESULT_OFS, acc, "window count");
         rd(STATUS_OFS, 32'h0, "gate low status");
         check("interrupt count", irqs - k, both ? 2 : 1);
      end
      // companion path to the shared pin
      apb(1'b1, CTRL2_OFS, 32'h00000010);
      repeat (3) @(negedge ref_clk);
      check("pin enable withheld", {31'h0, sharedPortPinOe}, 32'h0);
      check("pin out withheld", {31'h0, sharedPortPinOut}, 32'h0);
      @(posedge ref_clk);
      apb(1'b1, CTRL2_OFS, 32'h0);
      repeat (3) @(negedge ref_clk);
      check("pin enable driven", {31'h0, sharedPortPinOe}, 32'h1);
      check("pin out driven", {31'h0, sharedPortPinOut}, {31'h0, compHist[0]});
      @(posedge ref_clk);
      // gate select 11 gives no gate even with the pin high
      apb(1'b1, CTRL2_OFS, 32'h00000003);
      u_src.drive(1'b1, 1'b0);
      repeat (12) @(posedge ref_clk);
      rd(STATUS_OFS, 32'h0, "no gate status");
      // gate select 01 shows the companion waveform as gate level
      apb(1'b1, CTRL2_OFS, 32'h00000001);
      for (int j = 0; j < 4; j++)
      begin
         apb(1'b0, STATUS_OFS, 32'h0);
         check("companion gate status", rdData, {31'h0, compHist[2]});
      end
      u_src.drive(1'b0, 1'b0);
      // internal gate: fast, slow ps 00 and 01, divider tap ps 10
      for (int c = 0; c < 4; c++)
      begin
         ps = (c == 0) ? 0 : c - 1;
         ta = (c == 0) ? 15 : 12 + int'(seed[1:0]);
         tb = (c == 0) ? 14 : 15;
         apb(1'b1, CTRL1_OFS, 32'h0000000C);
         slowMode <= (c == 1 || c == 2);
         apb(1'b1, PERIOD_OFS, {24'h0, 4'(tb), 4'(ta)});
         apb(1'b1, CTRL2_OFS, {24'h0, c == 3, 2'(ps), 5'b00110});
         apb(1'b1, CTRL1_OFS, 32'h0000000D);
         waitIrq(t0);
         waitIrq(t1);
         // low setting rewritten inside a low period
         apb(1'b1, PERIOD_OFS, {24'h0, 4'(tb - 1), 4'(ta)});
         waitIrq(t2);
         check("gate high span", t1 - t0, expPer(ta, ps, c == 0));
         check("gate low span", t2 - t1, expPer(tb, ps, c == 0));
         // next low period takes the new setting
         if (c > 0)
         begin
            waitIrq(t1);
            waitIrq(t2);
            check("new low span", t2 - t1, expPer(tb - 1, ps, 1'b0));
         end
      end
      give_verdict();
   end
endmodule : gated_frequency_counter_test
